// file: scm_pkg.sv
package scm_pkg;

  // channel_mode_zero layout
  localparam logic [7:0]  SCM_CM0_RESET      = 8'h00;
  localparam int          SCM_PROTO_LSB      = 5;
  localparam int          SCM_HANDSHAKE_BIT  = 4;
  localparam int          SCM_RSVD_BIT       = 3;
  localparam int          SCM_CRC_EN_BIT     = 2;
  localparam int          SCM_POLY_BIT       = 1;
  localparam int          SCM_PRESET_BIT     = 0;

  // crc constants
  localparam int          SCM_CRC_W          = 16;
  localparam logic [15:0] SCM_POLY_CRC16     = 16'h8005;
  localparam logic [15:0] SCM_POLY_CCITT     = 16'h1021;
  localparam logic [15:0] SCM_PRESET_ZERO    = 16'h0000;
  localparam logic [15:0] SCM_PRESET_ONES    = 16'hFFFF;
  localparam logic [4:0]  SCM_FCS_BITS       = 5'h10;

  // trailing bit length in half bits
  localparam logic [2:0]  SCM_STOP_HALVES_1  = 3'h2;
  localparam logic [2:0]  SCM_STOP_HALVES_15 = 3'h3;
  localparam logic [2:0]  SCM_STOP_HALVES_2  = 3'h4;

  typedef enum logic [2:0] {
    SCM_PROTO_ASYNC = 3'b000,
    SCM_PROTO_MONO  = 3'b001,
    SCM_PROTO_BISYN = 3'b010,
    SCM_PROTO_EXTSY = 3'b011,
    SCM_PROTO_HDLC  = 3'b100
  } scm_proto_t;

  typedef enum logic [1:0] {
    SCM_TX_RUN   = 2'b00,
    SCM_TX_DRAIN = 2'b01,
    SCM_TX_HALT  = 2'b10
  } scm_tx_st_t;

  typedef struct packed {
    logic [2:0] protocol_select;
    logic       handshake_en;
    logic       rsvd;
    logic       crc_enable;
    logic [1:0] check_poly_preset;
  } scm_cm0_t;

  typedef struct packed {
    logic       is_async;
    logic       is_byte_sync;
    logic       is_hdlc;
    logic       is_reserved;
    logic       handshake_en;
    logic       crc_active;
    logic       crc_ccitt;
    logic       crc_preset_ones;
    logic       crc_complement;
    logic [2:0] stop_halves;
  } scm_mode_t;

endpackage

// file: scm_mode_cfg.sv
// How it works
// - mode register zero returns to reset on hardware or channel reset.
// - bits 7-5 decode async, mono, bi, external sync, HDLC; rest reserved.
// - handshake off: cts/dcd plain inputs, rts plain output, no effect.
// - handshake on: cts/dcd auto in all modes, rts auto only async.
// - async, cts high: finish shift register, idle mark, no more loads.
// - sync, cts high: finish shift register, stop loads, flag underrun.
// - dcd high disables receive; partial character dropped, buffer kept.
// - async handshake: rts low while sending, else the rts control bit.
// - sync modes: rts follows the rts control bit regardless of sending.
// - rts rises one transmit clock after the line returns to mark.
// - bit 3 reserved, reads zero; software writes zero.
// - bit 2 enables crc in sync modes; reads zero in async.
// - HDLC with crc: received check field never reaches the buffer.
// - byte sync: crc sent and checked uncomplemented.
// - HDLC: crc sent complemented and checked as complemented.
// - async bits 1-0: stop length 1, 1.5, 2, 11 reserved.
// - sync bit 1 picks crc-16 or crc-ccitt for both calculators.
// - sync bit 0 presets both calculators to zeros or ones.
// - crc field goes onto the line most significant bit first.
`timescale 1ns/1ps
`default_nettype none
module scm_mode_cfg (
  // clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              rst_n_i,
  // register access and commands
  input  wire logic              cfg_wr_i,
  input  wire logic              cfg_rd_i,
  input  wire logic [7:0]        cfg_wdata_i,
  input  wire logic              chan_reset_i,
  output logic      [7:0]        cfg_rdata_o,
  output scm_pkg::scm_mode_t     mode_o,
  // modem pins
  input  wire logic              cts_n_i,
  input  wire logic              dcd_n_i,
  input  wire logic              rts_ctl_i,
  output logic                   rts_n_o,
  output logic                   cts_level_o,
  output logic                   dcd_level_o,
  // transmitter side
  input  wire logic              tx_busy_i,
  input  wire logic              tx_bit_en_i,
  input  wire logic              underrun_idle_select_i,
  output logic                   tx_load_ok_o,
  output logic                   tx_force_mark_o,
  output logic                   underrun_flag_o,
  output logic                   tx_idle_crc_o,
  // transmit crc
  input  wire logic              tx_crc_init_i,
  input  wire logic              tx_crc_bit_en_i,
  input  wire logic              tx_crc_data_i,
  input  wire logic              tx_crc_emit_i,
  output logic                   tx_crc_bit_o,
  // receiver side
  input  wire logic              rx_assembling_i,
  output logic                   rx_enable_o,
  output logic                   rx_discard_o,
  output logic                   rx_fcs_strip_o,
  // receive crc
  input  wire logic              rx_crc_init_i,
  input  wire logic              rx_crc_bit_en_i,
  input  wire logic              rx_crc_data_i,
  input  wire logic              rx_crc_end_i,
  output logic                   crc_error_flag_o
);
  import scm_pkg::*;

  function automatic logic [15:0] scm_crc_step(input logic [15:0] c, input logic b,
                                               input logic ccitt);
    logic fb;
    fb = c[15] ^ b;
    scm_crc_step = {c[14:0], 1'b0} ^ (fb ? (ccitt ? SCM_POLY_CCITT : SCM_POLY_CRC16)
                                         : SCM_PRESET_ZERO);
  endfunction

  function automatic scm_mode_t scm_decode(input scm_cm0_t r);
    scm_mode_t m;
    m                 = '0;
    m.is_async        = (r.protocol_select == SCM_PROTO_ASYNC);
    m.is_byte_sync    = (r.protocol_select == SCM_PROTO_MONO) ||
                        (r.protocol_select == SCM_PROTO_BISYN) ||
                        (r.protocol_select == SCM_PROTO_EXTSY);
    m.is_hdlc         = (r.protocol_select == SCM_PROTO_HDLC);
    m.is_reserved     = !(m.is_async || m.is_byte_sync || m.is_hdlc);
    m.handshake_en    = r.handshake_en;
    m.crc_active      = r.crc_enable && !m.is_async;
    m.crc_ccitt       = r.check_poly_preset[SCM_POLY_BIT];
    m.crc_preset_ones = r.check_poly_preset[SCM_PRESET_BIT];
    m.crc_complement  = m.is_hdlc;
    case (r.check_poly_preset)
      2'b01:   m.stop_halves = SCM_STOP_HALVES_15;
      2'b10:   m.stop_halves = SCM_STOP_HALVES_2;
      // reserved code falls back to one bit
      default: m.stop_halves = SCM_STOP_HALVES_1;
    endcase
    scm_decode = m;
  endfunction

  // register and decode
  scm_cm0_t   cm0_r,   cm0_nxt;
  scm_mode_t  mode_r,  mode_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  always_comb begin
    cm0_nxt   = cm0_r;
    rdata_nxt = rdata_r;
    if (chan_reset_i) begin
      cm0_nxt = scm_cm0_t'(SCM_CM0_RESET);
    end else if (cfg_wr_i) begin
      cm0_nxt      = scm_cm0_t'(cfg_wdata_i);
      cm0_nxt.rsvd = 1'b0;
    end
    if (cfg_rd_i) begin
      rdata_nxt                 = cm0_r;
      rdata_nxt[SCM_RSVD_BIT]   = 1'b0;
      if (cm0_r.protocol_select == SCM_PROTO_ASYNC) begin
        rdata_nxt[SCM_CRC_EN_BIT] = 1'b0;
      end
    end
    mode_nxt = scm_decode(cm0_nxt);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cm0_r   <= scm_cm0_t'(SCM_CM0_RESET);
      mode_r  <= '0;
      rdata_r <= 8'h00;
    end else begin
      cm0_r   <= cm0_nxt;
      mode_r  <= mode_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // pin synchronisers; first stage feeds only the second
  logic cts_meta_r, cts_sync_r, cts_prev_r;
  logic dcd_meta_r, dcd_sync_r, dcd_prev_r;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cts_meta_r <= 1'b1;
      cts_sync_r <= 1'b1;
      cts_prev_r <= 1'b1;
      dcd_meta_r <= 1'b1;
      dcd_sync_r <= 1'b1;
      dcd_prev_r <= 1'b1;
    end else begin
      cts_meta_r <= cts_n_i;
      cts_sync_r <= cts_meta_r;
      cts_prev_r <= cts_sync_r;
      dcd_meta_r <= dcd_n_i;
      dcd_sync_r <= dcd_meta_r;
      dcd_prev_r <= dcd_sync_r;
    end
  end

  // transmit gating and rts
  scm_tx_st_t tx_st_r,    tx_st_nxt;
  logic       load_ok_r,  load_ok_nxt;
  logic       mark_r,     mark_nxt;
  logic       underrun_flag_r,     underrun_flag_nxt;
  logic       idle_crc_r, idle_crc_nxt;
  logic       rts_r,      rts_nxt;
  logic       rts_hold_r, rts_hold_nxt;
  logic       cts_off;

  always_comb begin
    tx_st_nxt    = tx_st_r;
    underrun_flag_nxt     = 1'b0;
    rts_hold_nxt = rts_hold_r;
    // cts high only matters with handshake on, in every protocol
    cts_off      = mode_r.handshake_en && cts_sync_r;
    case (tx_st_r)
      SCM_TX_RUN: begin
        if (cts_off) begin
          tx_st_nxt = SCM_TX_DRAIN;
        end
      end
      SCM_TX_DRAIN: begin
        // the word already in the shift register still goes out
        if (!tx_busy_i) begin
          tx_st_nxt = SCM_TX_HALT;
          underrun_flag_nxt  = !mode_r.is_async;
        end
      end
      SCM_TX_HALT: begin
        if (!cts_off) begin
          tx_st_nxt = SCM_TX_RUN;
        end
      end
      default: tx_st_nxt = SCM_TX_RUN;
    endcase
    load_ok_nxt  = (tx_st_nxt == SCM_TX_RUN);
    mark_nxt     = mode_r.is_async && (tx_st_nxt == SCM_TX_HALT);
    idle_crc_nxt = !mode_r.is_async && (tx_st_nxt == SCM_TX_HALT) &&
                   underrun_idle_select_i;
    if (mode_r.handshake_en && mode_r.is_async) begin
      if (tx_busy_i) begin
        rts_nxt      = 1'b0;
        rts_hold_nxt = 1'b1;
      end else if (rts_hold_r) begin
        // line is at mark; release on the next transmit clock
        rts_nxt      = 1'b0;
        if (tx_bit_en_i) begin
          rts_nxt      = rts_ctl_i;
          rts_hold_nxt = 1'b0;
        end
      end else begin
        rts_nxt = rts_ctl_i;
      end
    end else begin
      rts_nxt      = rts_ctl_i;
      rts_hold_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_st_r    <= SCM_TX_RUN;
      load_ok_r  <= 1'b1;
      mark_r     <= 1'b0;
      underrun_flag_r     <= 1'b0;
      idle_crc_r <= 1'b0;
      rts_r      <= 1'b1;
      rts_hold_r <= 1'b0;
    end else begin
      tx_st_r    <= tx_st_nxt;
      load_ok_r  <= load_ok_nxt;
      mark_r     <= mark_nxt;
      underrun_flag_r     <= underrun_flag_nxt;
      idle_crc_r <= idle_crc_nxt;
      rts_r      <= rts_nxt;
      rts_hold_r <= rts_hold_nxt;
    end
  end

  // receive gating
  logic rx_en_r, rx_en_nxt;
  logic disc_r,  disc_nxt;

  always_comb begin
    rx_en_nxt = !(mode_r.handshake_en && dcd_sync_r);
    // only the partial character goes; the buffer is untouched
    disc_nxt  = mode_r.handshake_en && dcd_sync_r && !dcd_prev_r &&
                rx_assembling_i;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_en_r <= 1'b1;
      disc_r  <= 1'b0;
    end else begin
      rx_en_r <= rx_en_nxt;
      disc_r  <= disc_nxt;
    end
  end

  // crc calculators
  logic [15:0] txc_r,  txc_nxt;
  logic        txb_r,  txb_nxt;
  logic [15:0] rxc_r,  rxc_nxt;
  logic [15:0] hist_r, hist_nxt;
  logic [4:0]  cnt_r,  cnt_nxt;
  logic        err_r,  err_nxt;
  logic [15:0] preset;

  always_comb begin
    preset   = mode_r.crc_preset_ones ? SCM_PRESET_ONES : SCM_PRESET_ZERO;
    txc_nxt  = txc_r;
    rxc_nxt  = rxc_r;
    hist_nxt = hist_r;
    cnt_nxt  = cnt_r;
    err_nxt  = err_r;
    if (tx_crc_init_i) begin
      txc_nxt = preset;
    end else if (tx_crc_bit_en_i && mode_r.crc_active) begin
      if (tx_crc_emit_i) begin
        txc_nxt = {txc_r[14:0], 1'b0};
      end else begin
        txc_nxt = scm_crc_step(txc_r, tx_crc_data_i, mode_r.crc_ccitt);
      end
    end
    txb_nxt = txc_nxt[15] ^ mode_r.crc_complement;
    // received check field trails the calculator by its own width
    if (rx_crc_init_i) begin
      rxc_nxt  = preset;
      hist_nxt = 16'h0000;
      cnt_nxt  = 5'h00;
    end else if (rx_crc_bit_en_i && mode_r.crc_active) begin
      hist_nxt = {hist_r[14:0], rx_crc_data_i};
      if (cnt_r == SCM_FCS_BITS) begin
        rxc_nxt = scm_crc_step(rxc_r, hist_r[15], mode_r.crc_ccitt);
      end else begin
        cnt_nxt = cnt_r + 5'h01;
      end
    end
    if (rx_crc_end_i && mode_r.crc_active) begin
      err_nxt = (cnt_r != SCM_FCS_BITS) ||
                (hist_r != (mode_r.crc_complement ? ~rxc_r : rxc_r));
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      txc_r  <= SCM_PRESET_ZERO;
      txb_r  <= 1'b0;
      rxc_r  <= SCM_PRESET_ZERO;
      hist_r <= SCM_PRESET_ZERO;
      cnt_r  <= 5'h00;
      err_r  <= 1'b0;
    end else begin
      txc_r  <= txc_nxt;
      txb_r  <= txb_nxt;
      rxc_r  <= rxc_nxt;
      hist_r <= hist_nxt;
      cnt_r  <= cnt_nxt;
      err_r  <= err_nxt;
    end
  end

  // receiver holds back the trailing check field in HDLC
  logic strip_r;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strip_r <= 1'b0;
    end else begin
      strip_r <= mode_nxt.is_hdlc && mode_nxt.crc_active;
    end
  end

  assign cfg_rdata_o      = rdata_r;
  assign mode_o           = mode_r;
  assign rts_n_o          = rts_r;
  assign cts_level_o      = cts_prev_r;
  assign dcd_level_o      = dcd_prev_r;
  assign tx_load_ok_o     = load_ok_r;
  assign tx_force_mark_o  = mark_r;
  assign underrun_flag_o  = underrun_flag_r;
  assign tx_idle_crc_o    = idle_crc_r;
  assign tx_crc_bit_o     = txb_r;
  assign rx_enable_o      = rx_en_r;
  assign rx_discard_o     = disc_r;
  assign rx_fcs_strip_o   = strip_r;
  assign crc_error_flag_o = err_r;

endmodule // scm_mode_cfg
`default_nettype wire

// file: scm_mode_cfg_props.sv
`timescale 1ns/1ps
`default_nettype none
module scm_mode_cfg_props (
  // clock and reset
  input wire logic               ref_clk_i,
  input wire logic               rst_n_i,
  // register port
  input wire logic               cfg_wr_i,
  input wire logic               cfg_rd_i,
  input wire logic [7:0]         cfg_wdata_i,
  input wire logic               chan_reset_i,
  input wire logic [7:0]         cfg_rdata_o,
  input wire scm_pkg::scm_mode_t mode_o,
  // modem and line side
  input wire logic               rts_ctl_i,
  input wire logic               rts_n_o,
  input wire logic               tx_busy_i,
  input wire logic               dcd_level_o,
  input wire logic               underrun_flag_o,
  input wire logic               rx_enable_o
);
  import scm_pkg::*;
  logic [7:0] wd_q;
  // written value kept one edge for the decode checks
  always_ff @(posedge ref_clk_i) wd_q <= cfg_wdata_i;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_clear_read;
    chan_reset_i ##1 (cfg_rd_i && !chan_reset_i);
  endsequence
  sequence s_sync_mode;
    (mode_o.is_byte_sync || mode_o.is_hdlc) [*2];
  endsequence
  property p_clear;
    s_clear_read |=> cfg_rdata_o == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("read after clear not zero");
  property p_rsvd;
    cfg_rd_i |=> !cfg_rdata_o[3];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit read as one");
  property p_async_crc;
    cfg_rd_i && mode_o.is_async |=> !cfg_rdata_o[2];
  endproperty
  a_async_crc: assert property (p_async_crc) else $error("crc bit seen in async");
  property p_proto;
    cfg_wr_i && !chan_reset_i |=> mode_o.is_hdlc == (wd_q[7:5] == 3'b100)
      && mode_o.is_async == (wd_q[7:5] == 3'b000);
  endproperty
  a_proto: assert property (p_proto) else $error("protocol decode wrong");
  property p_stop;
    cfg_wr_i && !chan_reset_i && cfg_wdata_i[7:5] == 3'b000 |=> mode_o.stop_halves ==
      (wd_q[1:0] == 2'b01 ? 3'h3 : (wd_q[1:0] == 2'b10 ? 3'h4 : 3'h2));
  endproperty
  a_stop: assert property (p_stop) else $error("stop length wrong");
  property p_compl;
    mode_o.is_byte_sync || mode_o.is_hdlc |-> mode_o.crc_complement == mode_o.is_hdlc;
  endproperty
  a_compl: assert property (p_compl) else $error("crc polarity wrong");
  property p_sync_rts;
    s_sync_mode |-> rts_n_o == $past(rts_ctl_i);
  endproperty
  a_sync_rts: assert property (p_sync_rts) else $error("sync rts not control bit");
  property p_async_rts;
    (mode_o.is_async && mode_o.handshake_en && tx_busy_i) ##1
      (mode_o.is_async && mode_o.handshake_en) |-> !rts_n_o;
  endproperty
  a_async_rts: assert property (p_async_rts) else $error("rts high while sending");
  property p_dcd;
    (mode_o.handshake_en && dcd_level_o) [*3] |-> !rx_enable_o;
  endproperty
  a_dcd: assert property (p_dcd) else $error("receive on without carrier");
  property p_underrun;
    underrun_flag_o |-> !mode_o.is_async ##1 !underrun_flag_o;
  endproperty
  a_underrun: assert property (p_underrun) else $error("underrun pulse wrong");
endmodule // scm_mode_cfg_props
bind scm_mode_cfg scm_mode_cfg_props u_props (.ref_clk_i, .rst_n_i, .cfg_wr_i, .cfg_rd_i,
  .cfg_wdata_i, .chan_reset_i, .cfg_rdata_o, .mode_o, .rts_ctl_i, .rts_n_o, .tx_busy_i,
  .dcd_level_o, .underrun_flag_o, .rx_enable_o);
`default_nettype wire

// file: scm_modem_model.sv
`timescale 1ns/1ps
`default_nettype none
module scm_modem_model (
  // clock and requests
  input  wire logic clk_i,
  input  wire logic slow_i,
  input  wire logic cts_off_i,
  input  wire logic dcd_off_i,
  // modem pins, high means not ready
  output var logic  cts_n_o,
  output var logic  dcd_n_o
);
  logic [3:0] cts_r = 4'h0;
  logic [3:0] dcd_r = 4'h0;
  // slow mode lags a few edges, like a sluggish modem
  always @(posedge clk_i) begin
    cts_r <= {cts_r[2:0], cts_off_i};
    dcd_r <= {dcd_r[2:0], dcd_off_i};
  end
  assign cts_n_o = slow_i ? cts_r[3] : cts_r[0];
  assign dcd_n_o = slow_i ? dcd_r[3] : dcd_r[0];
endmodule // scm_modem_model
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import scm_pkg::*;
  logic ref_clk_i, rst_n_i, cfg_wr_i, cfg_rd_i, chan_reset_i, rts_ctl_i, tx_busy_i;
  logic tx_bit_en_i, underrun_idle_select_i, tx_crc_init_i, tx_crc_bit_en_i, tx_crc_data_i;
  logic tx_crc_emit_i, rx_assembling_i, rx_crc_init_i, rx_crc_bit_en_i, rx_crc_data_i;
  logic rx_crc_end_i, cts_n_i, dcd_n_i, cts_off, dcd_off, slow;
  logic [7:0] cfg_wdata_i, cfg_rdata_o;
  scm_mode_t mode_o;
  logic rts_n_o, cts_level_o, dcd_level_o, tx_load_ok_o, tx_force_mark_o, underrun_flag_o;
  logic tx_idle_crc_o, tx_crc_bit_o, rx_enable_o, rx_discard_o, rx_fcs_strip_o;
  logic crc_error_flag_o;
  logic [15:0] c, f;
  logic [7:0] d = 8'hA5;
  int fails, n_tests, cycles;

  scm_mode_cfg u_dut (.ref_clk_i, .rst_n_i, .cfg_wr_i, .cfg_rd_i, .cfg_wdata_i, .chan_reset_i,
    .cfg_rdata_o, .mode_o, .cts_n_i, .dcd_n_i, .rts_ctl_i, .rts_n_o, .cts_level_o,
    .dcd_level_o, .tx_busy_i, .tx_bit_en_i, .underrun_idle_select_i, .tx_load_ok_o,
    .tx_force_mark_o, .underrun_flag_o, .tx_idle_crc_o, .tx_crc_init_i, .tx_crc_bit_en_i,
    .tx_crc_data_i, .tx_crc_emit_i, .tx_crc_bit_o, .rx_assembling_i, .rx_enable_o,
    .rx_discard_o, .rx_fcs_strip_o, .rx_crc_init_i, .rx_crc_bit_en_i, .rx_crc_data_i,
    .rx_crc_end_i, .crc_error_flag_o);
  scm_modem_model u_modem (.clk_i(ref_clk_i), .slow_i(slow), .cts_off_i(cts_off),
    .dcd_off_i(dcd_off), .cts_n_o(cts_n_i), .dcd_n_o(dcd_n_i));

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic final_report();
    $display("comparisons=%0d mismatches=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // hang guard, far above the thousand or so cycles needed
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      final_report();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // idle edge after each strobe so no signal is set twice in one step
  task automatic pls(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(1);
  endtask
  task automatic wt(ref logic s, input logic v);
    for (int i = 0; i < 30 && s !== v; i++) cyc(1);
    chk(s, v);
  endtask
  task automatic rd_chk(input logic [7:0] exp);
    pls(cfg_rd_i);
    chk(cfg_rdata_o, exp);
  endtask
  // channel reset ahead of every mode change
  task automatic wr_mode(input logic [7:0] v);
    pls(chan_reset_i);
    cfg_wdata_i = v;
    pls(cfg_wr_i);
  endtask
  task automatic step(input logic b);
    {tx_crc_data_i, rx_crc_data_i} = {b, b};
    {tx_crc_bit_en_i, rx_crc_bit_en_i} = 2'b11;
    cyc(1);
    {tx_crc_bit_en_i, rx_crc_bit_en_i} = 2'b00;
    cyc(1);
  endtask
  function automatic logic [15:0] crc_nx(input logic [15:0] v, input logic b, input logic cc);
    return {v[14:0], 1'b0} ^ ((v[15] ^ b) ? (cc ? SCM_POLY_CCITT : SCM_POLY_CRC16) : 16'h0000);
  endfunction

  initial begin
    {rst_n_i, cfg_wr_i, cfg_rd_i, chan_reset_i, tx_busy_i, tx_bit_en_i, underrun_idle_select_i,
      tx_crc_init_i, tx_crc_bit_en_i, tx_crc_data_i, tx_crc_emit_i, rx_assembling_i,
      rx_crc_init_i, rx_crc_bit_en_i, rx_crc_data_i, rx_crc_end_i, cts_off, dcd_off, slow} = '0;
    cfg_wdata_i = 8'h00;
    rts_ctl_i = 1'b1;
    repeat (5) @(posedge ref_clk_i);
    #1 rst_n_i = 1'b1;
    chk({tx_load_ok_o, rx_enable_o, rts_n_o}, 3'b111);
    rd_chk(8'h00);
    for (int p = 0; p < 5; p++) begin
      wr_mode(8'(p * 32 + 13));
      rd_chk(8'(p * 32 + (p != 0 ? 5 : 1)));
      chk({mode_o.is_async, mode_o.is_byte_sync, mode_o.is_hdlc}, {p == 0, p inside {[1:3]}, p == 4});
    end
    cfg_wdata_i = 8'hF7;
    {cfg_wr_i, chan_reset_i} = 2'b11;
    cyc(1);
    // read right behind the clear, so the clear-then-read check has work to do
    {cfg_wr_i, chan_reset_i, cfg_rd_i} = 3'b001;
    cyc(1);
    cfg_rd_i = 1'b0;
    cyc(1);
    chk(cfg_rdata_o, 8'h00);
    rd_chk(8'h00);
    for (int s = 0; s < 3; s++) begin
      wr_mode(8'(s));
      chk(mode_o.stop_halves, 16'(s + 2));
    end
    wr_mode(8'h10);
    tx_busy_i = 1'b1;
    cyc(2);
    chk(rts_n_o, 0);
    cts_off = 1'b1;
    wt(tx_load_ok_o, 0);
    chk(cts_level_o, 1);
    tx_busy_i = 1'b0;
    wt(tx_force_mark_o, 1);
    cyc(4);
    chk(rts_n_o, 0);
    pls(tx_bit_en_i);
    chk(rts_n_o, 1);
    cts_off = 1'b0;
    wt(tx_load_ok_o, 1);
    slow = 1'b1;
    wr_mode(8'h30);
    {underrun_idle_select_i, tx_busy_i, cts_off} = 3'b111;
    cyc(12);
    chk({rts_n_o, tx_force_mark_o}, 2'b10);
    tx_busy_i = 1'b0;
    wt(underrun_flag_o, 1);
    cyc(1);
    chk({underrun_flag_o, tx_idle_crc_o, tx_load_ok_o}, 3'b010);
    cts_off = 1'b0;
    wr_mode(8'h90);
    {rx_assembling_i, dcd_off} = 2'b11;
    wt(rx_discard_o, 1);
    cyc(1);
    chk(rx_enable_o, 0);
    chk(dcd_level_o, 1);
    wr_mode(8'h00);
    cts_off = 1'b1;
    cyc(8);
    chk({rx_enable_o, tx_load_ok_o}, 2'b11);
    {rx_assembling_i, dcd_off, cts_off, slow} = '0;
    // all polynomial and preset pairs, ccitt with ones among them
    for (int m = 0; m < 16; m++) begin
      wr_mode({m[2] ? 3'b100 : 3'b010, 3'b001, m[1:0]});
      c = m[0] ? SCM_PRESET_ONES : SCM_PRESET_ZERO;
      {tx_crc_init_i, rx_crc_init_i} = 2'b11;
      cyc(1);
      {tx_crc_init_i, rx_crc_init_i} = 2'b00;
      cyc(1);
      chk({tx_crc_bit_o, rx_fcs_strip_o}, {c[15] ^ m[2], m[2]});
      for (int i = 7; i >= 0; i--) begin
        c = crc_nx(c, d[i], m[1]);
        step(d[i]);
        chk(tx_crc_bit_o, c[15] ^ m[2]);
      end
      f = c ^ {16{m[2]}};
      tx_crc_emit_i = 1'b1;
      for (int i = 15; i >= 0; i--) begin
        chk(tx_crc_bit_o, f[i]);
        step(f[i] ^ (m[3] && i == 3));
      end
      tx_crc_emit_i = 1'b0;
      pls(rx_crc_end_i);
      chk(crc_error_flag_o, m[3]);
    end
    final_report();
  end
endmodule // testbench
`default_nettype wire
